/* inc/tcw_map.vh */
// Constants for the tag feature configuration word block.
// Assumes bit addresses within the EPC bank as seen by the protocol engine.
`ifndef TCW_MAP_VH
`define TCW_MAP_VH
`define TCW_CFG_BASE 10'h200
`define TCW_BIT_EPC_ACTIVE 4'h0
`define TCW_BIT_EPC_SINGLE_CORRECTED 4'h1
`define TCW_BIT_EPC_FAIL 4'h2
`define TCW_BIT_COMBINED 4'h3
`define TCW_BIT_BRAND 4'h4
`define TCW_BIT_CAP1 4'h5
`define TCW_BIT_CAP0 4'h6
`define TCW_BIT_ADJ_DIS 4'h7
`define TCW_BIT_MAX_BS 4'h9
`define TCW_BIT_USR_ACTIVE 4'hc
`define TCW_BIT_USR_CORR 4'hd
`define TCW_BIT_USR_FAIL 4'he
`define TCW_BIT_PSF 4'hf
`define TCW_ADDR_COMBINED 10'h203
`define TCW_ADDR_BRAND 10'h204
`define TCW_ADDR_PSF 10'h20f
`define TCW_PERM_MASK 16'h8280
`define TCW_PERM_RESET 16'h0200
`define TCW_TID_CFG_IND_BIT 8'h14
`define TCW_XTID_LSB 7'd48
`define TCW_ADJ_STEPS 2'd3
`endif

/* src/tcw_config_word.v */
// Feature configuration word logic of a passive UHF tag.
// Assumes a protocol engine decodes SELECT, WRITE and Lock and pulses here.
// Behaviour
// - 16-bit feature word lives at EPC bit address 200h
// - Action-bit features stay on until chip reset
// - Writing one toggles a permanent bit; zero does nothing; read shows state
// - Permanent bits change by single WRITE only, subject to EPC lock state
// - Action fires only on exact pointer, length 1, mask 1; one per SELECT
// - Truncated SELECT ignored; action SELECT leaves protocol state alone
// - Action bits trigger under any EPC lock condition
// - Indicator bits are read-only
// - ECC corrects single-bit errors, flags double-bit errors
// - EPC bits 200h-202h report check, correction, double fail; raw on fail
// - User bits 20Ch-20Eh report check, correction, double fail; raw on fail
// - Checking active on lock; secured write to locked bank disables it
// - TID carries manufacture-fixed even parity, checked by the reader
// - Lock checks programming margin; insufficient margin gives error
// - Startup picks one of three capacitances unless 207h forces center
// - Bits 205h/206h show active capacitor; start low, step upward
// - Brand trigger adds brand code XOR RN16 to the inventory reply
// - Combined trigger makes ACK reply EPC then TID
// - SELECT on 20Fh lets only flagged tags reply
// - Max backscatter default; clearing 209h selects lower level
// - Delivered EPC equals TID with extended header zeroed
// - TID bit 14h reads one to announce the configuration word
`timescale 1ns/1ps
`include "tcw_map.vh"
`default_nettype none
module tcw_config_word #(
  parameter [15:0] BRAND_CODE = 16'h5a3c // Arbitrary value
) (
  input wire ref_clk,
  input wire reset,
  input wire sel_valid,
  input wire sel_truncate,
  input wire [9:0] sel_pointer,
  input wire [7:0] sel_length,
  input wire sel_mask,
  input wire wr_valid,
  input wire wr_block,
  input wire [15:0] wr_data,
  input wire secured,
  input wire epc_locked,
  input wire epc_permalocked,
  input wire epc_pw_locked,
  input wire usr_locked,
  input wire usr_pw_locked,
  input wire usr_secured_write,
  input wire epc_secured_write,
  input wire [15:0] perm_stored,
  input wire perm_stored_valid,
  input wire epc_ecc_single,
  input wire epc_ecc_double,
  input wire usr_ecc_single,
  input wire usr_ecc_double,
  input wire lock_req,
  input wire lock_margin_ok,
  input wire [1:0] rssi_best,
  input wire [15:0] rn16,
  input wire [5:0] pc_epc_len,
  input wire [95:0] tid_word,
  output reg [15:0] cfg_word_q,
  output reg [15:0] perm_store_q,
  output reg perm_store_we_q,
  output reg combined_id_reply_q,
  output reg brand_reply_q,
  output reg [15:0] brand_field_q,
  output reg psf_select_q,
  output reg tid_only_q,
  output reg psf_may_reply_q,
  output reg raw_epc_read_q,
  output reg raw_usr_read_q,
  output reg lock_done_q,
  output reg lock_error_q,
  output reg [1:0] cap_sel_q,
  output reg max_backscatter_q,
  output reg tid_cfg_indicator_q,
  output reg tid_parity_q,
  output reg [95:0] default_epc_q,
  output reg sel_consumed_q
);
  localparam [3:0] ADJ_IDLE = 4'b0001;
  localparam [3:0] ADJ_STEP = 4'b0010;
  localparam [3:0] ADJ_DONE = 4'b0100;
  localparam [3:0] ADJ_FIX = 4'b1000;

  reg [15:0] perm_q;
  reg combined_q;
  reg brand_q;
  reg epc_active_q, epc_single_corrected_q, epc_fail_q;
  reg usr_active_q, usr_corr_q, usr_fail_q;
  reg epc_lock_seen_q, usr_lock_seen_q;
  reg [3:0] adj_state_q;
  reg [1:0] adj_cnt_q;
  reg loaded_q;
  wire sel_exact;
  wire perm_wr_ok;
  wire [15:0] perm_d;

  // Selects on action bits are filtered here and never reach inventory state
  assign sel_exact = sel_valid && !sel_truncate && sel_length == 8'h01 &&
    sel_mask;
  // A write before the stored bits are loaded would be overwritten by the load
  assign perm_wr_ok = loaded_q && wr_valid && !wr_block && !epc_permalocked &&
    (!epc_locked || secured);
  assign perm_d = perm_q ^ (wr_data & `TCW_PERM_MASK);

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      perm_q <= `TCW_PERM_RESET;
      loaded_q <= 1'b0;
      perm_store_q <= 16'h0000;
      perm_store_we_q <= 1'b0;
    end else begin
      perm_store_we_q <= 1'b0;
      if (!loaded_q && perm_stored_valid) begin
        perm_q <= perm_stored & `TCW_PERM_MASK;
        loaded_q <= 1'b1;
      end else if (perm_wr_ok) begin
        perm_q <= perm_d;
        perm_store_q <= perm_d;
        perm_store_we_q <= 1'b1;
      end
    end
  end

  // Action flags are volatile; only reset clears them
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      combined_q <= 1'b0;
      brand_q <= 1'b0;
      psf_select_q <= 1'b0;
      sel_consumed_q <= 1'b0;
    end else begin
      sel_consumed_q <= sel_exact && (sel_pointer == `TCW_ADDR_COMBINED ||
        sel_pointer == `TCW_ADDR_BRAND || sel_pointer == `TCW_ADDR_PSF);
      // Lock state is not consulted: actions work even when permalocked
      if (sel_exact && sel_pointer == `TCW_ADDR_COMBINED)
        combined_q <= 1'b1;
      if (sel_exact && sel_pointer == `TCW_ADDR_BRAND)
        brand_q <= 1'b1;
      if (sel_exact && sel_pointer == `TCW_ADDR_PSF)
        psf_select_q <= 1'b1;
    end
  end

  // Error sticky flags; set wins over the disable path
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      epc_active_q <= 1'b0;
      epc_single_corrected_q <= 1'b0;
      epc_fail_q <= 1'b0;
      usr_active_q <= 1'b0;
      usr_corr_q <= 1'b0;
      usr_fail_q <= 1'b0;
      epc_lock_seen_q <= 1'b0;
      usr_lock_seen_q <= 1'b0;
    end else begin
      epc_lock_seen_q <= epc_locked;
      usr_lock_seen_q <= usr_locked;
      if (epc_locked && !epc_lock_seen_q)
        epc_active_q <= 1'b1;
      else if (epc_pw_locked && epc_secured_write)
        epc_active_q <= 1'b0;
      if (usr_locked && !usr_lock_seen_q)
        usr_active_q <= 1'b1;
      else if (usr_pw_locked && usr_secured_write)
        usr_active_q <= 1'b0;
      if (epc_active_q && epc_ecc_single && !epc_ecc_double)
        epc_single_corrected_q <= 1'b1;
      if (epc_active_q && epc_ecc_double)
        epc_fail_q <= 1'b1;
      if (usr_active_q && usr_ecc_single && !usr_ecc_double)
        usr_corr_q <= 1'b1;
      if (usr_active_q && usr_ecc_double)
        usr_fail_q <= 1'b1;
    end
  end

  // Self adjust walks low to high capacitance once after startup
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      adj_state_q <= ADJ_IDLE;
      adj_cnt_q <= 2'd0;
      cap_sel_q <= 2'b10;
    end else begin
      case (adj_state_q)
        ADJ_IDLE: begin
          if (loaded_q) begin
            if (perm_q[`TCW_BIT_ADJ_DIS]) begin
              cap_sel_q <= 2'b00;
              adj_state_q <= ADJ_FIX;
            end else begin
              cap_sel_q <= 2'b10;
              adj_cnt_q <= 2'd1;
              adj_state_q <= ADJ_STEP;
            end
          end
        end
        ADJ_STEP: begin
          // Stop at the best reported step or after three settings
          if (rssi_best == adj_cnt_q || adj_cnt_q == `TCW_ADJ_STEPS) begin
            adj_state_q <= ADJ_DONE;
          end else begin
            adj_cnt_q <= adj_cnt_q + 2'd1;
            cap_sel_q <= (adj_cnt_q == 2'd1) ? 2'b00 : 2'b01;
          end
        end
        ADJ_DONE: adj_state_q <= ADJ_DONE;
        ADJ_FIX: adj_state_q <= ADJ_FIX;
        default: adj_state_q <= ADJ_IDLE;
      endcase
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfg_word_q <= 16'h0000;
      combined_id_reply_q <= 1'b0;
      brand_reply_q <= 1'b0;
      brand_field_q <= 16'h0000;
      tid_only_q <= 1'b0;
      psf_may_reply_q <= 1'b0;
      raw_epc_read_q <= 1'b0;
      raw_usr_read_q <= 1'b0;
      lock_done_q <= 1'b0;
      lock_error_q <= 1'b0;
      max_backscatter_q <= 1'b1;
      tid_cfg_indicator_q <= 1'b0;
      tid_parity_q <= 1'b0;
      default_epc_q <= 96'h0;
    end else begin
      cfg_word_q <= perm_q;
      cfg_word_q[`TCW_BIT_EPC_ACTIVE] <= epc_active_q;
      cfg_word_q[`TCW_BIT_EPC_SINGLE_CORRECTED] <= epc_single_corrected_q;
      cfg_word_q[`TCW_BIT_EPC_FAIL] <= epc_fail_q;
      cfg_word_q[`TCW_BIT_COMBINED] <= combined_q;
      cfg_word_q[`TCW_BIT_BRAND] <= brand_q;
      cfg_word_q[`TCW_BIT_CAP1] <= cap_sel_q[0];
      cfg_word_q[`TCW_BIT_CAP0] <= cap_sel_q[1];
      cfg_word_q[`TCW_BIT_USR_ACTIVE] <= usr_active_q;
      cfg_word_q[`TCW_BIT_USR_CORR] <= usr_corr_q;
      cfg_word_q[`TCW_BIT_USR_FAIL] <= usr_fail_q;
      combined_id_reply_q <= combined_q;
      tid_only_q <= combined_q && pc_epc_len == 6'd0;
      brand_reply_q <= brand_q;
      brand_field_q <= BRAND_CODE ^ rn16;
      psf_may_reply_q <= !psf_select_q || perm_q[`TCW_BIT_PSF];
      raw_epc_read_q <= epc_fail_q;
      raw_usr_read_q <= usr_fail_q;
      lock_done_q <= lock_req && lock_margin_ok;
      lock_error_q <= lock_req && !lock_margin_ok;
      max_backscatter_q <= perm_q[`TCW_BIT_MAX_BS];
      tid_cfg_indicator_q <= 1'b1;
      tid_parity_q <= ^tid_word;
      default_epc_q <= tid_word;
      default_epc_q[`TCW_XTID_LSB +: 16] <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

/* test/tcw_props.sv */
// Port checker for the feature configuration word block.
// Assumes it is bound onto every instance of tcw_config_word.
`timescale 1ns/1ps
`default_nettype none
module tcw_props (
  input wire ref_clk,
  input wire reset,
  input wire sel_valid,
  input wire sel_truncate,
  input wire [9:0] sel_pointer,
  input wire [7:0] sel_length,
  input wire sel_mask,
  input wire wr_valid,
  input wire wr_block,
  input wire epc_permalocked,
  input wire lock_req,
  input wire lock_margin_ok,
  input wire sel_consumed_q,
  input wire brand_reply_q,
  input wire combined_id_reply_q,
  input wire perm_store_we_q,
  input wire lock_done_q,
  input wire lock_error_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_trunc_ignored: assert property (
    sel_valid && sel_truncate |=> !sel_consumed_q) else $error("trunc");
  chk_bad_length: assert property (
    sel_valid && sel_length != 8'h01 |=> !sel_consumed_q) else $error("len");
  chk_brand_fires: assert property (
    sel_valid && !sel_truncate && sel_pointer == 10'h204 && sel_mask &&
    sel_length == 8'h01 |-> ##2 brand_reply_q) else $error("brand");
  chk_action_sticky: assert property (
    brand_reply_q || combined_id_reply_q |=> $stable({brand_reply_q,
    combined_id_reply_q})) else $error("sticky");
  chk_block_refused: assert property (
    wr_valid && wr_block |=> !perm_store_we_q) else $error("blockwrite");
  chk_perma_refused: assert property (
    wr_valid && epc_permalocked |=> !perm_store_we_q) else $error("perma");
  chk_margin_bad: assert property (
    lock_req && !lock_margin_ok |=> lock_error_q && !lock_done_q)
    else $error("margin bad");
  chk_margin_good: assert property (
    lock_req && lock_margin_ok |=> lock_done_q && !lock_error_q)
    else $error("margin good");
endmodule
bind tcw_config_word tcw_props tcw_props_i (.*);
`default_nettype wire

/* test/tcw_reader_model.sv */
// Reader side: descrambles the brand reply and recomputes TID parity.
// Assumes the bench feeds it the tag's reply fields.
`timescale 1ns/1ps
`default_nettype none
module tcw_reader_model (
  input wire logic [15:0] brand_field,
  input wire logic [15:0] rn16,
  input wire logic [95:0] tid_word,
  output logic [15:0] brand_seen,
  output logic parity_calc
);
  assign brand_seen = brand_field ^ rn16;
  assign parity_calc = ^tid_word;
endmodule
`default_nettype wire

/* test/tcw_config_word_bench.sv */
// Bench for the feature configuration word block.
// Assumes the checker is bound in and the reader model is compiled.
`timescale 1ns/1ps
`default_nettype none
module tcw_config_word_bench;
  localparam logic [15:0] BRAND = 16'h2b6d; // Arbitrary value
  logic ref_clk, reset, sel_valid, sel_truncate, sel_mask, wr_valid;
  logic wr_block, secured, epc_locked, epc_permalocked, epc_pw_locked;
  logic usr_locked, usr_pw_locked, usr_secured_write, epc_secured_write;
  logic perm_stored_valid, epc_ecc_single, epc_ecc_double, usr_ecc_single;
  logic usr_ecc_double, lock_req, lock_margin_ok, perm_store_we_q;
  logic combined_id_reply_q, brand_reply_q, psf_select_q, tid_only_q;
  logic psf_may_reply_q, raw_epc_read_q, raw_usr_read_q, lock_done_q;
  logic lock_error_q, max_backscatter_q, tid_cfg_indicator_q, tid_parity_q;
  logic sel_consumed_q, parity_calc;
  logic [9:0] sel_pointer;
  logic [7:0] sel_length;
  logic [15:0] wr_data, perm_stored, rn16, cfg_word_q, perm_store_q, v;
  logic [15:0] brand_field_q, brand_seen;
  logic [1:0] rssi_best, cap_sel_q;
  logic [5:0] pc_epc_len;
  logic [95:0] tid_word, default_epc_q;
  integer n_mismatch = 0;
  integer check_count = 0;
  tcw_config_word #(.BRAND_CODE(BRAND)) tcw_config_word_i (.*);
  tcw_reader_model tcw_reader_model_i (.brand_field(brand_field_q),
    .rn16(rn16), .tid_word(tid_word), .brand_seen(brand_seen),
    .parity_calc(parity_calc));
  initial begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic sel(input logic [9:0] p, input logic [7:0] l, input logic m, t);
    {sel_pointer, sel_length, sel_mask, sel_truncate} = {p, l, m, t};
    sel_valid = 1;
    step(1);
    sel_valid = 0;
    step(2);
  endtask
  task automatic wr(input logic [15:0] d, input logic b);
    {wr_data, wr_block, wr_valid} = {d, b, 1'b1};
    step(1);
    wr_valid = 0;
    step(2);
  endtask
  // One-cycle event pulses: secured write, lock, usr/epc double, epc single
  task automatic evt(input logic [4:0] k);
    {epc_secured_write, lock_req, usr_ecc_double, epc_ecc_double,
      epc_ecc_single} = k;
    step(1);
    {epc_secured_write, lock_req, usr_ecc_double, epc_ecc_double,
      epc_ecc_single} = 5'h00;
    step(2);
  endtask
  initial begin
    {sel_valid, sel_truncate, sel_mask, wr_valid, wr_block, secured,
      epc_locked, epc_permalocked, epc_pw_locked, usr_locked, usr_pw_locked,
      usr_secured_write, epc_secured_write, perm_stored_valid, lock_req,
      epc_ecc_single, epc_ecc_double, usr_ecc_single, usr_ecc_double} = '0;
    {lock_margin_ok, sel_pointer, sel_length, wr_data} = '0;
    {perm_stored, rn16, rssi_best, pc_epc_len} = {16'h0200, 16'h1234, 8'h86};
    tid_word = 96'he280_6894_2000_1a2b_3c4d_5e6f;
    reset = 1;
    repeat (16) @(posedge ref_clk);
    #1 reset = 0;
    perm_stored_valid = 1;
    step(1);
    perm_stored_valid = 0;
    step(3);
    chk("max_bs", 1'b1, max_backscatter_q);
    chk("tid_ind", 1'b1, tid_cfg_indicator_q);
    chk("tid_par", parity_calc, tid_parity_q);
    chk("cap_sel", 2'b00, cap_sel_q);
    chk("epc_xtid", 16'h0000, default_epc_q[63:48]);
    chk("epc_hi", 16'he280, default_epc_q[95:80]);
    wr(16'h0000, 0);
    chk("zero_wr", 16'h0200, cfg_word_q & 16'h8280);
    wr(16'h0200, 0);
    chk("bs_low", 1'b0, max_backscatter_q);
    chk("store", 16'h0000, perm_store_q);
    wr(16'h8000, 1);
    chk("block_wr", 16'h0000, cfg_word_q & 16'h8280);
    epc_locked = 1;
    wr(16'h0080, 0);
    chk("locked_wr", 16'h0000, cfg_word_q & 16'h8280);
    chk("epc_chk", 1'b1, cfg_word_q[0]);
    secured = 1;
    wr(16'h8080, 0);
    chk("sec_wr", 16'h8080, cfg_word_q & 16'h8280);
    chk("psf_reply", 1'b1, psf_may_reply_q);
    epc_permalocked = 1;
    wr(16'h8280, 0);
    chk("perma_wr", 16'h8080, cfg_word_q & 16'h8280);
    v = cfg_word_q & 16'h707f;
    wr(16'h707f, 0);
    chk("ind_ro", v, cfg_word_q & 16'h707f);
    evt(5'h01);
    chk("epc_single_corrected", 1'b1, cfg_word_q[1]);
    evt(5'h02);
    chk("epc_fail", 2'h3, {cfg_word_q[2], raw_epc_read_q});
    usr_locked = 1;
    step(1);
    evt(5'h04);
    chk("usr_fail", 3'h7, {cfg_word_q[12], cfg_word_q[14], raw_usr_read_q});
    evt(5'h08);
    lock_margin_ok = 1;
    evt(5'h08);
    epc_pw_locked = 1;
    evt(5'h10);
    chk("epc_off", 1'b0, cfg_word_q[0]);
    sel(10'h204, 8'h01, 1, 1);
    sel(10'h204, 8'h01, 0, 0);
    sel(10'h204, 8'h02, 1, 0);
    chk("brand_no", 1'b0, brand_reply_q);
    sel(10'h203, 8'h01, 1, 0);
    chk("combined", 2'h2, {combined_id_reply_q, brand_reply_q});
    pc_epc_len = 6'h00;
    step(2);
    chk("tid_only", 1'b1, tid_only_q);
    sel(10'h20f, 8'h01, 1, 0);
    chk("psf_sel", 1'b1, psf_select_q);
    // Reset before brand: the reader never combines both replies
    reset = 1;
    step(1);
    reset = 0;
    step(1);
    chk("act_clear", 1'b0, combined_id_reply_q);
    sel(10'h204, 8'h01, 1, 0);
    step(10);
    chk("brand", 1'b1, brand_reply_q);
    chk("brand_val", BRAND, brand_seen);
    tally_and_finish();
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
